// ==== src/bit_serial_line_scanner.sv ====
// serial bit channels with hardware line scan sequencer and apb slave
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module bit_serial_line_scanner #(
	parameter int NUM_CH = line_scan_pkg::NUM_CH_DEF,
	parameter int BIT_CYCLES = line_scan_pkg::BIT_CYC,
	parameter int HALF_BIT_CYCLES = line_scan_pkg::HALF_BIT_CYC,
	parameter int WORD_CYCLES = line_scan_pkg::WORD_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire line_scan_pkg::apb_req_t apb_req,
	output line_scan_pkg::apb_rsp_t apb_rsp,
	input wire logic [NUM_CH-1:0] rx_line,
	output logic [NUM_CH-1:0] tx_line,
	output logic [NUM_CH-1:0] carrier_on,
	output logic scan_busy
);
	import line_scan_pkg::*;

	localparam int CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

	typedef struct packed {
		chan_t [NUM_CH-1:0] ch;
		logic [NUM_CH-1:0][SW_W-1:0] sw1;
		logic [NUM_CH-1:0][SW_W-1:0] sw2;
		logic [NUM_CH-1:0][SW_W-1:0] sw3;
		logic [6:0] creg;
		logic [SW_W-1:0] work_a;
		logic [SW_W-1:0] work_b;
		scan_phase_t phase;
		logic [CNT_W-1:0] wcnt;
		logic [6:0] sch;
		logic ack;
		logic [31:0] prdata;
		logic pslverr;
	} state_t;

	localparam state_t ST_RST = '{ch: {NUM_CH{CHAN_RST}}, sw1: '0,
		sw2: '0, sw3: '0, creg: '0, work_a: '0, work_b: '0,
		phase: SCAN_IDLE, wcnt: '0, sch: '0, ack: 1'b0, prdata: '0,
		pslverr: 1'b0};

	state_t st;
	state_t next_st;
	logic rst_meta;
	logic rst_n;
	logic access;
	logic done;

	//======================================================================
	// helpers

	function automatic logic chan_ok(input logic [6:0] c);
		return int'(c) < NUM_CH;
	endfunction

	// one command on one channel, shared by software and the scan
	function automatic chan_t apply_cmd(input chan_t c, input logic [3:0] cmd);
		chan_t r;
		r = c;
		case (cmd)
			CLEAR_RECEIVE_COMMAND: begin
				r.rx_flag = 1'b0;
				r.rx_buf = 1'b0;
			end
			CLEAR_TRANSMIT_COMMAND: begin
				r.tx_flag = 1'b0;
				r.tx_buf = 1'b0;
			end
			RECEIVE_MODE_CARRIER_OFF: begin
				r.tx_mode = 1'b0;
				r.carrier = 1'b0;
			end
			TRANSMIT_MODE_CARRIER_ON: begin
				r.tx_mode = 1'b1;
				r.carrier = 1'b1;
			end
			STOP_RECEIVE_CLOCK: begin
				r.rx_run = 1'b0;
				r.rx_cnt = '0;
				r.flt_cnt = '0;
			end
			default: begin
			end
		endcase
		return r;
	endfunction

	//======================================================================
	// reset release, asserts at once and lets go after two edges
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	//======================================================================
	// next state: bus, then scan, then line timing so sets win over clears
	always_comb begin
		chan_t c;
		logic [SW_W-1:0] w2;
		logic [SW_W-1:0] w3;
		logic [3:0] lvl;
		logic [ASM_W-1:0] asm_n;
		logic [31:0] rdata;
		logic mapped;
		logic [CHW-1:0] ai;
		logic [CHW-1:0] si;
		logic ok;
		c = '0;
		w2 = '0;
		w3 = '0;
		lvl = '0;
		asm_n = '0;
		rdata = 32'h0000_0000;
		mapped = 1'b1;
		next_st = st;
		ai = st.creg[CHW-1:0];
		si = st.sch[CHW-1:0];
		ok = chan_ok(st.creg);
		access = apb_req.psel && apb_req.penable;
		done = (st.wcnt == CNT_W'(WORD_CYCLES - 1));

		// read data decode; unknown channels read as zero
		case (apb_req.paddr)
			OFS_CHAN: rdata = 32'(st.creg);
			OFS_EXT: begin
				if (chan_ok(st.creg)) begin
					rdata = 32'({st.ch[ai].rx_run, st.ch[ai].tx_mode,
						st.ch[ai].carrier, st.ch[ai].tx_flag,
						st.ch[ai].rx_flag});
				end
			end
			OFS_RX_DATA: begin
				if (chan_ok(st.creg)) begin
					rdata = 32'(st.ch[ai].rx_buf) << RX_DATA_POS;
				end
			end
			OFS_TX_DATA: rdata = ok ? 32'(st.ch[ai].tx_buf) : '0;
			OFS_SCAN: rdata = 32'(st.sch);
			OFS_WORK_A: rdata = 32'(st.work_a);
			OFS_WORK_B: rdata = 32'(st.work_b);
			OFS_SW1: rdata = ok ? 32'(st.sw1[ai]) : '0;
			OFS_SW2: rdata = ok ? 32'(st.sw2[ai]) : '0;
			OFS_SW3: rdata = ok ? 32'(st.sw3[ai]) : '0;
			default: mapped = 1'b0;
		endcase

		// first access cycle latches the answer; a running scan stalls it
		if (access && !st.ack && st.phase == SCAN_IDLE) begin
			next_st.ack = 1'b1;
			next_st.prdata = rdata;
			next_st.pslverr = !mapped;
		end

		// second access cycle completes, side effects happen here only
		if (access && st.ack) begin
			next_st.ack = 1'b0;
			if (apb_req.pwrite && mapped) begin
				case (apb_req.paddr)
					OFS_CHAN: next_st.creg = apb_req.pwdata[6:0];
					OFS_EXT: begin
						if (chan_ok(st.creg)) begin
							next_st.ch[ai] = apply_cmd(next_st.ch[ai],
								apb_req.pwdata[3:0]);
						end
					end
					OFS_TX_DATA: begin
						if (chan_ok(st.creg)) begin
							next_st.ch[ai].tx_buf = apb_req.pwdata[0];
							next_st.ch[ai].tx_flag = 1'b0;
						end
					end
					OFS_SCAN: begin
						next_st.phase = SCAN_SETUP;
						next_st.sch = apb_req.pwdata[6:0];
						next_st.wcnt = '0;
					end
					OFS_SW1: if (ok) next_st.sw1[ai] = apb_req.pwdata[SW_W-1:0];
					OFS_SW2: if (ok) next_st.sw2[ai] = apb_req.pwdata[SW_W-1:0];
					OFS_SW3: if (ok) next_st.sw3[ai] = apb_req.pwdata[SW_W-1:0];
					default: begin
					end
				endcase
			end else if (!apb_req.pwrite && apb_req.paddr == OFS_RX_DATA
				&& chan_ok(st.creg)) begin
				// taking the bit clears flag and buffer
				next_st.ch[ai] = apply_cmd(next_st.ch[ai],
					CLEAR_RECEIVE_COMMAND);
			end
		end

		// every phase lasts exactly one word time
		if (st.phase != SCAN_IDLE) begin
			next_st.wcnt = done ? '0 : st.wcnt + 1'b1;
		end

		// scan sequencer: setup word, then receive, transmit, step per channel
		if (done) begin
			unique case (st.phase)
				SCAN_IDLE: begin
				end
				SCAN_SETUP: begin
					next_st.phase = SCAN_RX;
				end
				SCAN_RX: begin
					next_st.phase = SCAN_TX;
					// scan tests the flag and moves the bit
					if (chan_ok(st.sch) && st.ch[si].rx_flag) begin
						w3 = st.sw3[si];
						// code level picks five to eight bits
						lvl = {2'b00, st.sw2[si][SW2_LVL_HI:SW2_LVL_LO]}
							+ BASE_LEVEL;
						next_st.ch[si] = apply_cmd(next_st.ch[si],
							CLEAR_RECEIVE_COMMAND);
						if (st.ch[si].rx_bits == 4'h0) begin
							w3[ASM_HI:ASM_LSB] = '0;
							next_st.ch[si].rx_bits = 4'h1;
						end else begin
							asm_n = {st.ch[si].rx_buf, w3[ASM_HI:ASM_LSB+1]};
							w3[ASM_HI:ASM_LSB] = asm_n;
							next_st.ch[si].rx_bits = st.ch[si].rx_bits + 4'h1;
							if (st.ch[si].rx_bits == lvl) begin
								// right align data at position two
								w3[RX_CHAR_HI:0] = {asm_n >> (4'h8 - lvl), 1'b0};
								w3[SW_READY_BIT] = 1'b1;
								next_st.ch[si].rx_bits = 4'h0;
								next_st.ch[si] = apply_cmd(next_st.ch[si],
									STOP_RECEIVE_CLOCK);
							end
						end
						next_st.sw3[si] = w3;
						next_st.work_a = w3;
					end
				end
				SCAN_TX: begin
					next_st.phase = SCAN_NEXT;
					if (chan_ok(st.sch) && st.ch[si].tx_flag) begin
						w2 = st.sw2[si];
						// field of one means last bit goes now
						// a missing marker falls back on last one
						if (w2[SHIFT_W-1:0] <= SHIFT_DONE) begin
							next_st.ch[si].tx_buf = 1'b1;
							w2[SHIFT_W-1:0] = st.sw1[si][SHIFT_W-1:0];
							w2[SW_READY_BIT] = 1'b1;
						end else begin
							// up to eleven units fit the field
							next_st.ch[si].tx_buf = w2[0];
							w2[SHIFT_W-1:0] = w2[SHIFT_W-1:0] >> 1;
						end
						next_st.ch[si].tx_flag = 1'b0;
						next_st.sw2[si] = w2;
						next_st.work_b = w2;
					end
				end
				SCAN_NEXT: begin
					next_st.creg = st.sch;
					// stop at marker, 63 or 127
					if ((chan_ok(st.sch) && st.sw2[si][SW2_LAST_BIT])
						|| st.sch == SCAN_LIMIT_DEF
						|| st.sch == SCAN_LIMIT_MAX) begin
						next_st.phase = SCAN_IDLE;
					end else begin
						next_st.sch = st.sch + 7'h01;
						next_st.phase = SCAN_RX;
					end
				end
			endcase
		end

		// line timing per channel, applied last so its sets win
		for (int i = 0; i < NUM_CH; i++) begin
			c = next_st.ch[i];
			c.s1 = rx_line[i];
			c.s2 = st.ch[i].s1;
			c.s3 = st.ch[i].s2;
			if (st.ch[i].s2 == st.ch[i].s3) begin
				c.level = st.ch[i].s3;
			end
			if (!c.rx_run) begin
				if (!st.ch[i].level) begin
					c.flt_cnt = c.flt_cnt + 1'b1;
					// only a half-bit space starts the clock
					if (c.flt_cnt == CNT_W'(HALF_BIT_CYCLES)) begin
						c.rx_run = 1'b1;
						c.rx_cnt = '0;
						c.flt_cnt = '0;
						c.rx_buf = 1'b0;
						c.rx_flag = 1'b1;
						c.rx_bits = 4'h0;
					end
				end else begin
					c.flt_cnt = '0;
				end
			end else if (c.rx_cnt == CNT_W'(BIT_CYCLES - 1)) begin
				// centre sample every bit until stopped
				// an unread bit is simply overwritten
				c.rx_cnt = '0;
				c.rx_buf = st.ch[i].level;
				c.rx_flag = 1'b1;
			end else begin
				c.rx_cnt = c.rx_cnt + 1'b1;
			end
			if (c.tx_cnt == CNT_W'(BIT_CYCLES - 1)) begin
				// every tick drives buffer and sets flag
				c.tx_cnt = '0;
				c.tx_line = c.tx_buf;
				c.tx_flag = 1'b1;
			end else begin
				c.tx_cnt = c.tx_cnt + 1'b1;
			end
			next_st.ch[i] = c;
		end
	end

	//======================================================================
	// the one state register; ce low freezes everything
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	//======================================================================
	// outputs straight from state
	assign apb_rsp.prdata = st.prdata;
	assign apb_rsp.pready = st.ack;
	assign apb_rsp.pslverr = st.pslverr;
	assign scan_busy = (st.phase != SCAN_IDLE);

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			tx_line[i] = st.ch[i].tx_line;
			carrier_on[i] = st.ch[i].carrier;
		end
	end

	//======================================================================
	// checks; helper counts scan cycles and channels
	int scan_cyc;
	int scan_n;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scan_cyc <= 0;
			scan_n <= 0;
		end else if (ce) begin
			if (st.phase == SCAN_IDLE) begin
				scan_cyc <= 0;
				scan_n <= 0;
			end else begin
				scan_cyc <= scan_cyc + 1;
				if (st.phase == SCAN_NEXT && done) begin
					scan_n <= scan_n + 1;
				end
			end
		end
	end

	// per channel checks, every line watched alike
	for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
		chk_rx_half_bit: assert property (
			@(posedge clk_sys) disable iff (!rst_n)
			$rose(st.ch[g].rx_run) |-> !$past(st.ch[g].level)
			&& $past(st.ch[g].flt_cnt) == CNT_W'(HALF_BIT_CYCLES - 1))
			else $error("receive clock started without half-bit space");

		// a stop landing on a sample tick halts the clock instead
		chk_rx_sample: assert property (
			@(posedge clk_sys) disable iff (!rst_n)
			ce && st.ch[g].rx_run
			&& st.ch[g].rx_cnt == CNT_W'(BIT_CYCLES - 1)
			|=> !st.ch[g].rx_run || (st.ch[g].rx_flag
			&& st.ch[g].rx_buf == $past(st.ch[g].level)))
			else $error("centre sample not buffered");

		chk_rx_stopped: assert property (
			@(posedge clk_sys) disable iff (!rst_n)
			ce && !st.ch[g].rx_run && !st.ch[g].rx_flag && st.ch[g].level
			|=> !st.ch[g].rx_flag)
			else $error("receive flag set with clock stopped");

		chk_rx_take: assert property (
			@(posedge clk_sys) disable iff (!rst_n)
			ce && access && st.ack && !apb_req.pwrite
			&& apb_req.paddr == OFS_RX_DATA && st.creg == 7'(g)
			&& st.ch[g].rx_run && st.ch[g].rx_cnt != CNT_W'(BIT_CYCLES - 1)
			|=> !st.ch[g].rx_flag && !st.ch[g].rx_buf)
			else $error("taking bit left flag or buffer");

		chk_carrier_cmd: assert property (
			@(posedge clk_sys) disable iff (!rst_n)
			ce && access && st.ack && apb_req.pwrite
			&& apb_req.paddr == OFS_EXT && st.creg == 7'(g)
			&& apb_req.pwdata[3:0] == TRANSMIT_MODE_CARRIER_ON
			|=> carrier_on[g])
			else $error("carrier not on after transmit mode");

		chk_tx_flag_tick: assert property (
			@(posedge clk_sys) disable iff (!rst_n)
			ce && st.ch[g].tx_cnt == CNT_W'(BIT_CYCLES - 1)
			|=> st.ch[g].tx_flag)
			else $error("transmit tick did not set flag");

		chk_tx_line_drive: assert property (
			@(posedge clk_sys) disable iff (!rst_n)
			ce && st.ch[g].tx_cnt == CNT_W'(BIT_CYCLES - 1) && !scan_busy
			&& !(access && st.ack && apb_req.pwrite)
			|=> tx_line[g] == $past(st.ch[g].tx_buf))
			else $error("line not driven from buffer");
	end

	chk_scan_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(scan_busy) |-> scan_cyc == WORD_CYCLES * (1 + 3 * scan_n))
		else $error("scan length not one plus three per channel");

	chk_scan_final: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(scan_busy) |-> st.creg == st.sch)
		else $error("final channel not left in channel register");

	chk_scan_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(scan_busy) |-> st.sch == SCAN_LIMIT_DEF
		|| st.sch == SCAN_LIMIT_MAX || st.sw2[st.sch[CHW-1:0]][SW2_LAST_BIT])
		else $error("scan ended at an unmarked channel");

endmodule

// ==== src/line_scan_pkg.sv ====
// constants, register map and bus, scan phase and channel types for the bit-serial line scanner
//==========================================================================
package line_scan_pkg;

	//======================================================================
	// timing
	localparam int CLK_NS = 8;
	localparam int BIT_TIME_NS = 8000;
	localparam int BIT_CYC = BIT_TIME_NS / CLK_NS;
	localparam int HALF_BIT_NS = BIT_TIME_NS / 2;
	// a least time, so round up
	localparam int HALF_BIT_CYC = (HALF_BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int WORD_TIME_NS = 64;
	localparam int WORD_CYC = WORD_TIME_NS / CLK_NS;
	localparam int CNT_W = 16;
	localparam int NUM_CH_DEF = 8;

	//======================================================================
	// register map, byte offsets on the apb
	localparam logic [11:0] OFS_CHAN = 12'h000;
	localparam logic [11:0] OFS_EXT = 12'h004;
	localparam logic [11:0] OFS_RX_DATA = 12'h008;
	localparam logic [11:0] OFS_TX_DATA = 12'h00c;
	localparam logic [11:0] OFS_SCAN = 12'h010;
	localparam logic [11:0] OFS_WORK_A = 12'h014;
	localparam logic [11:0] OFS_WORK_B = 12'h018;
	localparam logic [11:0] OFS_SW1 = 12'h020;
	localparam logic [11:0] OFS_SW2 = 12'h024;
	localparam logic [11:0] OFS_SW3 = 12'h028;
	localparam int RX_DATA_POS = 17;

	//======================================================================
	// scan word fields, bit index is position minus one
	// eighteen bit scan words
	localparam int SW_W = 18;
	localparam int SW_READY_BIT = 17;
	localparam int SW2_LVL_HI = 16;
	localparam int SW2_LVL_LO = 15;
	localparam int SW2_LAST_BIT = 12;
	localparam int SHIFT_W = 12;
	localparam logic [SHIFT_W-1:0] SHIFT_DONE = 12'h001;
	localparam int ASM_HI = 16;
	localparam int ASM_LSB = 9;
	localparam int ASM_W = 8;
	localparam int RX_CHAR_HI = 8;
	localparam logic [3:0] BASE_LEVEL = 4'h5;
	localparam logic [6:0] SCAN_LIMIT_DEF = 7'h3f;
	localparam logic [6:0] SCAN_LIMIT_MAX = 7'h7f;

	//======================================================================
	// external function command codes
	localparam logic [3:0] CLEAR_RECEIVE_COMMAND = 4'h1;
	localparam logic [3:0] CLEAR_TRANSMIT_COMMAND = 4'h2;
	localparam logic [3:0] RECEIVE_MODE_CARRIER_OFF = 4'h3;
	localparam logic [3:0] TRANSMIT_MODE_CARRIER_ON = 4'h4;
	localparam logic [3:0] STOP_RECEIVE_CLOCK = 4'h5;

	//======================================================================
	// types
	typedef enum logic [2:0] {
		SCAN_IDLE,
		SCAN_SETUP,
		SCAN_RX,
		SCAN_TX,
		SCAN_NEXT
	} scan_phase_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rx_run;
		logic [CNT_W-1:0] flt_cnt;
		logic [CNT_W-1:0] rx_cnt;
		logic rx_flag;
		logic rx_buf;
		logic [3:0] rx_bits;
		logic [CNT_W-1:0] tx_cnt;
		logic tx_flag;
		logic tx_buf;
		logic tx_line;
		logic tx_mode;
		logic carrier;
	} chan_t;

	// idle line is mark, so the synchroniser, level, transmit buffer and transmit line start at one
	localparam chan_t CHAN_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1,
		level: 1'b1, tx_buf: 1'b1, tx_line: 1'b1, default: '0};

endpackage

// ==== test/remote_terminal.sv ====
// remote start/stop terminal model: frame sender and frame catcher
`timescale 1ns/10ps
module remote_terminal #(
	parameter int BIT = 40
) (
	input wire logic clk_sys,
	input wire logic line_in,
	output logic line_out,
	output logic [7:0] cap
);
	logic [7:0] sh;
	initial begin
		line_out = 1'b1;
		cap = 8'h00;
	end
	//==================================================================
	// sender
	// units go lsb first; line rests at mark after the frame
	task automatic send_frame(input logic [11:0] f, input int n,
		input int hold);
		for (int i = 0; i < n; i++) begin
			line_out <= f[i];
			repeat (hold) @(posedge clk_sys);
		end
		line_out <= 1'b1;
	endtask
	//==================================================================
	// catcher
	// eight units sampled at their centres, start bit in bit 0
	initial begin
		forever begin
			@(posedge clk_sys);
			if (line_in === 1'b0) begin
				repeat (BIT / 2) @(posedge clk_sys);
				for (int i = 0; i < 8; i++) begin
					sh[i] = line_in;
					repeat (BIT) @(posedge clk_sys);
				end
				cap <= sh;
			end
		end
	end
endmodule

// ==== test/tb_top.sv ====
// testbench for the bit-serial line scanner over apb
`timescale 1ns/10ps
module tb_top;
	import line_scan_pkg::*;
	localparam int BIT = 40;
	localparam int WORD = 2;
	localparam int LIMIT = 20000;
	logic clk_sys;
	logic nrst;
	logic ce;
	apb_req_t req;
	apb_rsp_t rsp;
	logic [7:0] rx_line;
	logic [7:0] tx_line;
	logic [7:0] carrier_on;
	logic scan_busy;
	logic term_line;
	logic [7:0] cap;
	logic [31:0] q;
	logic [31:0] w;
	logic e;
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;
	int bcnt = 0;
	int b0;
	int st[3] = '{1, 60, 64};
	int nn[3] = '{2, 4, 64};
	// only channel 1 has a terminal; the rest idle at mark
	assign rx_line = {6'h3f, term_line, 1'b1};
	bit_serial_line_scanner #(.NUM_CH(8), .BIT_CYCLES(BIT),
		.HALF_BIT_CYCLES(20), .WORD_CYCLES(WORD)) bit_serial_line_scanner_inst (
		.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .apb_req(req),
		.apb_rsp(rsp), .rx_line(rx_line), .tx_line(tx_line),
		.carrier_on(carrier_on), .scan_busy(scan_busy));
	remote_terminal #(.BIT(BIT)) remote_terminal_inst (.clk_sys(clk_sys),
		.line_in(tx_line[1]), .line_out(term_line), .cap(cap));
	//==================================================================
	// clock, busy counter and timeout
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (scan_busy === 1'b1) bcnt <= bcnt + 1;
		if (cyc == LIMIT) begin
			miscompares++;
			results();
		end
	end
	//==================================================================
	// tasks
	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk_sys);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic wait_flag(input int b);
		int n;
		for (n = 0; n < 100; n++) begin
			rd(OFS_EXT);
			if (q[b] === 1'b1) break;
		end
		if (n == 100) begin
			miscompares++;
			$display("wrong value at %0t: flag %0d never set", $time, b);
		end
	endtask
	task automatic wait_line(input logic v);
		int n;
		for (n = 0; n < BIT + 10; n++) begin
			@(posedge clk_sys);
			if (tx_line[1] === v) break;
		end
		if (n == BIT + 10) begin
			miscompares++;
			$display("wrong value at %0t: line never at %b", $time, v);
		end
	endtask
	//==================================================================
	// main sequence
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		req = '0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk({tx_line, carrier_on, 7'h00, scan_busy}, 32'h00ff_0000, "reset");
		rd(12'h01c);
		chk({e, q[30:0]}, 32'h8000_0000, "unmapped");
		$display("test reset_and_map done");
		wr(OFS_CHAN, 32'h0000_0001);
		wr(OFS_EXT, {28'h000_0000, TRANSMIT_MODE_CARRIER_ON});
		@(posedge clk_sys);
		chk(carrier_on, 8'h02, "carrier on");
		rd(OFS_EXT);
		chk(q[3:2], 2'b11, "tx mode");
		wr(OFS_EXT, {28'h000_0000, RECEIVE_MODE_CARRIER_OFF});
		@(posedge clk_sys);
		chk(carrier_on, 8'h00, "carrier off");
		rd(OFS_EXT);
		chk(q[3:2], 2'b00, "rx mode");
		// manual transmit, synced to a tick
		wr(OFS_TX_DATA, 32'h0000_0001);
		wait_flag(1);
		wr(OFS_EXT, {28'h000_0000, CLEAR_TRANSMIT_COMMAND});
		rd(OFS_EXT);
		chk(q[1], 1'b0, "tx flag cleared");
		rd(OFS_TX_DATA);
		chk(q[0], 1'b0, "tx buffer cleared");
		wait_line(1'b0);
		chk(tx_line[1], 1'b0, "buffer on line");
		repeat (BIT) @(posedge clk_sys);
		chk(tx_line[1], 1'b0, "buffer repeats");
		wait_flag(1);
		wr(OFS_TX_DATA, 32'h0000_0001);
		rd(OFS_EXT);
		chk(q[1], 1'b0, "write clears flag");
		wait_line(1'b1);
		chk(tx_line[1], 1'b1, "mark again");
		$display("test manual_transmit done");
		remote_terminal_inst.send_frame(12'h000, 1, 10);
		repeat (BIT) @(posedge clk_sys);
		rd(OFS_EXT);
		chk(q[4] | q[0], 1'b0, "glitch ignored");
		fork
			remote_terminal_inst.send_frame(12'hffa, 10, BIT);
		join_none
		wait_flag(0);
		wr(OFS_EXT, {28'h000_0000, CLEAR_RECEIVE_COMMAND});
		rd(OFS_EXT);
		chk(q[0], 1'b0, "rx flag cleared");
		wait_flag(0);
		rd(OFS_RX_DATA);
		chk(q[17], 1'b1, "first data bit");
		rd(OFS_EXT);
		chk(q[0], 1'b0, "take clears flag");
		wait_flag(0);
		rd(OFS_RX_DATA);
		chk(q[17], 1'b0, "second data bit");
		wr(OFS_EXT, {28'h000_0000, STOP_RECEIVE_CLOCK});
		rd(OFS_EXT);
		chk(q[4], 1'b0, "clock stopped");
		repeat (12 * BIT) @(posedge clk_sys);
		rd(OFS_EXT);
		chk(q[0], 1'b0, "no flag after stop");
		$display("test manual_receive done");
		wr(OFS_CHAN, 32'h0000_0002);
		wr(OFS_SW2, 32'h0000_1000);
		for (int k = 0; k < 3; k++) begin
			b0 = bcnt;
			wr(OFS_SCAN, st[k]);
			rd(OFS_CHAN);
			chk(bcnt - b0, WORD * (1 + 3 * nn[k]), "scan time");
			chk(q[6:0], st[k] + nn[k] - 1, "final channel");
		end
		$display("test scan_span done");
		for (int lvl = 0; lvl < 4; lvl++) begin
			wr(OFS_CHAN, 32'h0000_0001);
			if (lvl == 0) wr(OFS_SW1, 32'h0000_01ea);
			wr(OFS_SW3, 32'h0000_0000);
			wr(OFS_SW2, (lvl << 15) | 1);
			fork
				remote_terminal_inst.send_frame(12'hffe, 11, BIT);
			join_none
			repeat (20) begin
				wr(OFS_SCAN, 32'h0000_0001);
				repeat (20) @(posedge clk_sys);
			end
			wr(OFS_CHAN, 32'h0000_0001);
			rd(OFS_SW3);
			chk({q[17], q[8:0]}, {1'b1, 9'(((1 << (5 + lvl)) - 1) << 1)},
				"received char");
			// last receive step with data leaves its word in work a
			w = q;
			rd(OFS_WORK_A);
			chk(q, w, "work register");
			if (lvl == 0) begin
				chk(cap, 8'hea, "sent char");
				rd(OFS_SW2);
				chk(q[17], 1'b1, "tx ready");
				wr(OFS_SW1, 32'h0000_0fff);
			end
		end
		$display("test scanned_traffic done");
		results();
	end
endmodule
